// File: hw/hcf_regs.svh
// Offsets, bit positions and reset values of the host control flags
`ifndef HCF_REGS_SVH
`define HCF_REGS_SVH

`define HCF_ADDR_W          8
`define HCF_SET_OFS         8'h50
`define HCF_CLR_OFS         8'h54

`define HCF_BIT_ROM_VALID   31
`define HCF_BIT_SWAP_BYPASS 30
`define HCF_BIT_LATE_ACK    29
`define HCF_RSV_HI          28
`define HCF_RSV_LO          24
`define HCF_BIT_CFG_OWNER   23

`define HCF_RST_ROM_VALID   1'b0
`define HCF_RST_SWAP_BYPASS 1'b0
`define HCF_RST_LATE_ACK    1'b0
`define HCF_RST_CFG_OWNER   1'b1
`define HCF_RST_RDATA       32'h0000_0000

`endif

// File: hw/hcf_pkg.sv
// Types shared by the host control flag block
package hcf_pkg;

	typedef enum logic [3:0] {
		HCF_ACK_COMPLETE   = 4'h1,
		HCF_ACK_PENDING    = 4'h2,
		HCF_ACK_TARDY      = 4'hB,
		HCF_ACK_TYPE_ERROR = 4'hE
	} hcf_ack_type;

	typedef enum logic [1:0] {
		HCF_REQ_OTHER     = 2'b00,
		HCF_REQ_ROM_BLOCK = 2'b01,
		HCF_REQ_ROM_LOCK  = 2'b10
	} hcf_req_type;

endpackage : hcf_pkg

// File: hw/hcf_flags_if.sv
// Flag levels passed from the register bank to the acknowledge unit
`timescale 1ns/1ps
interface hcf_flags_if;
	logic link_active;
	logic rom_image_valid;
	logic late_ack_permit;

	modport owner (output link_active, output rom_image_valid, output late_ack_permit);
	modport user  (input link_active, input rom_image_valid, input late_ack_permit);
endinterface : hcf_flags_if

// File: hw/hcf_swap.sv
// DMA data byte swapper, registered
`timescale 1ns/1ps
module hcf_swap #(
	parameter int W = 32
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         bypass,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	output logic [W-1:0]      out_data
);
	function automatic logic [W-1:0] byte_rev(input logic [W-1:0] d);
		logic [W-1:0] r;
		r = '0;
		for (int i = 0; i < W / 8; i++) begin
			r[8*i +: 8] = d[W-8-8*i +: 8];
		end
		return r;
	endfunction : byte_rev

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
		end else begin
			out_valid <= in_valid;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_data <= '0;
		end else if (in_valid) begin
			out_data <= bypass ? in_data : byte_rev(in_data);
		end
	end

	property p_swap_applied;
		@(posedge clock) disable iff (!rst_n)
		in_valid && !bypass |=> out_valid && out_data == byte_rev($past(in_data));
	endproperty
	a_swap_applied: assert property (p_swap_applied) else $error("swap not applied");

	property p_swap_bypassed;
		@(posedge clock) disable iff (!rst_n)
		in_valid && bypass |=> out_valid && out_data == $past(in_data);
	endproperty
	a_swap_bypassed: assert property (p_swap_bypassed) else $error("bypass data altered");
endmodule : hcf_swap

// File: hw/hcf_ack.sv
// Acknowledge decision for asynchronous requests addressed to this node
`timescale 1ns/1ps
module hcf_ack (
	input  wire logic         clock,
	input  wire logic         rst_n,
	hcf_flags_if.user         flg,
	input  wire logic         req_valid,
	input  hcf_pkg::hcf_req_type req_kind,
	output logic              ack_valid,
	output hcf_pkg::hcf_ack_type ack_code,
	output logic              rom_serve,
	output logic              fwd_valid,
	output logic              tardy_event
);
	import hcf_pkg::*;

	logic take;
	logic is_rom;
	assign take   = req_valid && flg.link_active;
	assign is_rom = (req_kind == HCF_REQ_ROM_BLOCK) || (req_kind == HCF_REQ_ROM_LOCK);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_valid   <= 1'b0;
			ack_code    <= HCF_ACK_COMPLETE;
			rom_serve   <= 1'b0;
			fwd_valid   <= 1'b0;
			tardy_event <= 1'b0;
		end else begin
			ack_valid   <= 1'b0;
			rom_serve   <= 1'b0;
			fwd_valid   <= 1'b0;
			tardy_event <= 1'b0;
			if (take) begin
				if (flg.late_ack_permit) begin
					ack_valid   <= 1'b1;
					ack_code    <= HCF_ACK_TARDY;
					tardy_event <= 1'b1;
				end else if (is_rom && flg.rom_image_valid) begin
					ack_valid <= 1'b1;
					ack_code  <= HCF_ACK_PENDING;
					rom_serve <= 1'b1;
				end else if (is_rom) begin
					ack_valid <= 1'b1;
					ack_code  <= HCF_ACK_TYPE_ERROR;
				end else begin
					fwd_valid <= 1'b1;
				end
			end
		end
	end

	property p_tardy_flags_event;
		@(posedge clock) disable iff (!rst_n)
		ack_valid && ack_code == HCF_ACK_TARDY |-> tardy_event;
	endproperty
	a_tardy_flags_event: assert property (p_tardy_flags_event) else $error("tardy without event");

	property p_tardy_all;
		@(posedge clock) disable iff (!rst_n)
		take && flg.late_ack_permit |=> ack_valid && ack_code == HCF_ACK_TARDY && !fwd_valid;
	endproperty
	a_tardy_all: assert property (p_tardy_all) else $error("late mode did not answer tardy");

	property p_rom_refused;
		@(posedge clock) disable iff (!rst_n)
		take && !flg.late_ack_permit && req_kind == HCF_REQ_ROM_BLOCK && !flg.rom_image_valid
		|=> ack_valid && ack_code == HCF_ACK_TYPE_ERROR && !rom_serve;
	endproperty
	a_rom_refused: assert property (p_rom_refused) else $error("invalid rom read not refused");

	property p_rom_served;
		@(posedge clock) disable iff (!rst_n)
		take && !flg.late_ack_permit && is_rom && flg.rom_image_valid |=> rom_serve && ack_valid;
	endproperty
	a_rom_served: assert property (p_rom_served) else $error("valid rom read not served");

	property p_detached;
		@(posedge clock) disable iff (!rst_n)
		!flg.link_active |=> !ack_valid && !fwd_valid && !rom_serve && !tardy_event;
	endproperty
	a_detached: assert property (p_detached) else $error("activity while detached");
endmodule : hcf_ack

// File: hw/hcf_host_ctrl.sv
// Host control upper flags: set/clear register pair, acknowledge and swap control
`timescale 1ns/1ps
`include "hcf_regs.svh"
module hcf_host_ctrl #(
	parameter int DMA_W = 32
) (
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	input  wire logic [`HCF_ADDR_W-1:0]    reg_addr,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [31:0]               reg_wdata,
	output logic [31:0]                    reg_rdata,
	output logic                           reg_rvalid,
	input  wire logic                      link_active,
	input  wire logic                      sw_reset,
	input  wire logic                      bus_reset,
	input  wire logic                      bib_fetch_error,
	input  wire logic                      eeprom_load,
	input  wire logic                      eeprom_owner,
	input  wire logic                      req_valid,
	input  hcf_pkg::hcf_req_type           req_kind,
	output logic                           ack_valid,
	output hcf_pkg::hcf_ack_type           ack_code,
	output logic                           rom_serve,
	output logic                           fwd_valid,
	output logic                           tardy_event,
	output logic                           rom_regs_reload,
	output logic                           rom_image_valid,
	output logic                           swap_bypass,
	output logic                           late_ack_permit,
	output logic                           enhancement_config_owner,
	input  wire logic                      dma_in_valid,
	input  wire logic [DMA_W-1:0]          dma_in_data,
	output logic                           dma_out_valid,
	output logic [DMA_W-1:0]               dma_out_data
);
	import hcf_pkg::*;

	logic        rom_image_valid_r;
	logic        swap_bypass_r;
	logic        late_ack_permit_r;
	logic        cfg_owner_r;
	logic        reload_r;
	logic [31:0] rdata_r;
	logic        rvalid_r;
	logic        set_hit;
	logic        clr_hit;
	logic        map_hit;
	logic [31:0] flags_view;

	hcf_flags_if flg ();

	// Both ports decode on the full offset; any other offset reads zero
	assign set_hit = reg_wr && (reg_addr == `HCF_SET_OFS);
	assign clr_hit = reg_wr && (reg_addr == `HCF_CLR_OFS);
	assign map_hit = (reg_addr == `HCF_SET_OFS) || (reg_addr == `HCF_CLR_OFS);

	// Lower half and bits 22..16 belong to neighbouring logic and read zero here
	always_comb begin
		flags_view                        = 32'h0000_0000;
		flags_view[`HCF_BIT_ROM_VALID]    = rom_image_valid_r;
		flags_view[`HCF_BIT_SWAP_BYPASS]  = swap_bypass_r;
		flags_view[`HCF_BIT_LATE_ACK]     = late_ack_permit_r;
		flags_view[`HCF_BIT_CFG_OWNER]    = cfg_owner_r;
	end

	// Clear port has no effect on this bit; only the three causes below drop it
	always_ff @(posedge clock) begin
		if (!rst_n || sw_reset || bib_fetch_error) begin
			rom_image_valid_r <= `HCF_RST_ROM_VALID;
		end else if (set_hit && reg_wdata[`HCF_BIT_ROM_VALID] && !link_active) begin
			rom_image_valid_r <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n || sw_reset) begin
			swap_bypass_r <= `HCF_RST_SWAP_BYPASS;
		end else if (set_hit && reg_wdata[`HCF_BIT_SWAP_BYPASS]) begin
			swap_bypass_r <= 1'b1;
		end else if (clr_hit && reg_wdata[`HCF_BIT_SWAP_BYPASS]) begin
			swap_bypass_r <= 1'b0;
		end
	end

	// Bus manager status is unknown here, so the hardware cannot refuse this set
	always_ff @(posedge clock) begin
		if (!rst_n || sw_reset) begin
			late_ack_permit_r <= `HCF_RST_LATE_ACK;
		end else if (set_hit && reg_wdata[`HCF_BIT_LATE_ACK]) begin
			late_ack_permit_r <= 1'b1;
		end else if (clr_hit && reg_wdata[`HCF_BIT_LATE_ACK]) begin
			late_ack_permit_r <= 1'b0;
		end
	end

	// Owner bit ignores both ports; software reset keeps the EEPROM value
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfg_owner_r <= `HCF_RST_CFG_OWNER;
		end else if (eeprom_load) begin
			cfg_owner_r <= eeprom_owner;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reload_r <= 1'b0;
		end else begin
			reload_r <= bus_reset && rom_image_valid_r;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= `HCF_RST_RDATA;
		end else begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				rdata_r <= map_hit ? flags_view : 32'h0000_0000;
			end
		end
	end

	assign flg.link_active     = link_active;
	assign flg.rom_image_valid = rom_image_valid_r;
	assign flg.late_ack_permit = late_ack_permit_r;

	hcf_ack u_ack (
		.clock       (clock),
		.rst_n       (rst_n),
		.flg         (flg),
		.req_valid   (req_valid),
		.req_kind    (req_kind),
		.ack_valid   (ack_valid),
		.ack_code    (ack_code),
		.rom_serve   (rom_serve),
		.fwd_valid   (fwd_valid),
		.tardy_event (tardy_event)
	);

	hcf_swap #(
		.W (DMA_W)
	) u_swap (
		.clock     (clock),
		.rst_n     (rst_n),
		.bypass    (swap_bypass_r),
		.in_valid  (dma_in_valid),
		.in_data   (dma_in_data),
		.out_valid (dma_out_valid),
		.out_data  (dma_out_data)
	);

	assign reg_rdata                = rdata_r;
	assign reg_rvalid               = rvalid_r;
	assign rom_regs_reload          = reload_r;
	assign rom_image_valid          = rom_image_valid_r;
	assign swap_bypass              = swap_bypass_r;
	assign late_ack_permit          = late_ack_permit_r;
	assign enhancement_config_owner = cfg_owner_r;

	sequence s_set_swap;
		set_hit && reg_wdata[`HCF_BIT_SWAP_BYPASS] && !sw_reset;
	endsequence

	sequence s_read_set_port;
		reg_rd && reg_addr == `HCF_SET_OFS;
	endsequence

	sequence s_swap_kept;
		!(clr_hit && reg_wdata[`HCF_BIT_SWAP_BYPASS]) && !sw_reset;
	endsequence

	property p_rom_valid_link_down;
		@(posedge clock) disable iff (!rst_n)
		$rose(rom_image_valid_r) |-> $past(!link_active);
	endproperty
	a_rom_valid_link_down: assert property (p_rom_valid_link_down) else $error("rom valid set while linked");

	property p_rom_valid_sticky;
		@(posedge clock) disable iff (!rst_n)
		rom_image_valid_r && !sw_reset && !bib_fetch_error |=> rom_image_valid_r;
	endproperty
	a_rom_valid_sticky: assert property (p_rom_valid_sticky) else $error("rom valid dropped");

	property p_rom_valid_drop;
		@(posedge clock) disable iff (!rst_n)
		sw_reset || bib_fetch_error |=> !rom_image_valid_r;
	endproperty
	a_rom_valid_drop: assert property (p_rom_valid_drop) else $error("rom valid not cleared");

	property p_no_reload_invalid;
		@(posedge clock) disable iff (!rst_n)
		bus_reset && !rom_image_valid_r |=> !rom_regs_reload;
	endproperty
	a_no_reload_invalid: assert property (p_no_reload_invalid) else $error("reload with invalid image");

	property p_set_then_read;
		@(posedge clock) disable iff (!rst_n)
		s_set_swap ##1 s_swap_kept ##1 s_read_set_port
		|=> reg_rvalid && reg_rdata[`HCF_BIT_SWAP_BYPASS];
	endproperty
	a_set_then_read: assert property (p_set_then_read) else $error("set bit not read back");

	property p_clear_port;
		@(posedge clock) disable iff (!rst_n)
		clr_hit && reg_wdata[`HCF_BIT_LATE_ACK] && !set_hit |=> !late_ack_permit;
	endproperty
	a_clear_port: assert property (p_clear_port) else $error("clear port ineffective");

	property p_zero_keeps;
		@(posedge clock) disable iff (!rst_n)
		reg_wr && !reg_wdata[`HCF_BIT_SWAP_BYPASS] && !sw_reset |=> $stable(swap_bypass);
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed flag");

	property p_reserved_zero;
		@(posedge clock) disable iff (!rst_n)
		reg_rvalid |-> reg_rdata[`HCF_RSV_HI:`HCF_RSV_LO] == 5'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

	property p_owner_readonly;
		@(posedge clock) disable iff (!rst_n)
		!eeprom_load |=> $stable(enhancement_config_owner);
	endproperty
	a_owner_readonly: assert property (p_owner_readonly) else $error("owner bit changed");

	property p_reload_valid;
		@(posedge clock) disable iff (!rst_n)
		bus_reset && rom_image_valid_r |=> rom_regs_reload;
	endproperty
	a_reload_valid: assert property (p_reload_valid) else $error("valid image not reloaded");

	property p_reload_quiet;
		@(posedge clock) disable iff (!rst_n)
		!bus_reset |=> !rom_regs_reload;
	endproperty
	a_reload_quiet: assert property (p_reload_quiet) else $error("reload without bus reset");

	property p_rom_set;
		@(posedge clock) disable iff (!rst_n)
		set_hit && reg_wdata[`HCF_BIT_ROM_VALID] && !link_active && !sw_reset && !bib_fetch_error
		|=> rom_image_valid_r;
	endproperty
	a_rom_set: assert property (p_rom_set) else $error("rom valid set ignored");

	property p_rom_set_refused;
		@(posedge clock) disable iff (!rst_n)
		set_hit && reg_wdata[`HCF_BIT_ROM_VALID] && link_active && !rom_image_valid_r
		|=> !rom_image_valid_r;
	endproperty
	a_rom_set_refused: assert property (p_rom_set_refused) else $error("rom valid set while linked");

	property p_swap_clear;
		@(posedge clock) disable iff (!rst_n)
		clr_hit && reg_wdata[`HCF_BIT_SWAP_BYPASS] && !sw_reset |=> !swap_bypass;
	endproperty
	a_swap_clear: assert property (p_swap_clear) else $error("swap bypass not cleared");

	property p_late_set;
		@(posedge clock) disable iff (!rst_n)
		set_hit && reg_wdata[`HCF_BIT_LATE_ACK] && !sw_reset |=> late_ack_permit;
	endproperty
	a_late_set: assert property (p_late_set) else $error("late ack permit not set");

	property p_sw_reset_clears;
		@(posedge clock) disable iff (!rst_n)
		sw_reset |=> !rom_image_valid && !swap_bypass && !late_ack_permit;
	endproperty
	a_sw_reset_clears: assert property (p_sw_reset_clears) else $error("software reset left flags");

	property p_owner_load;
		@(posedge clock) disable iff (!rst_n)
		eeprom_load |=> enhancement_config_owner == $past(eeprom_owner);
	endproperty
	a_owner_load: assert property (p_owner_load) else $error("owner bit not loaded");

	property p_read_answer;
		@(posedge clock) disable iff (!rst_n)
		reg_rd |=> reg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_read_quiet;
		@(posedge clock) disable iff (!rst_n)
		!reg_rd |=> !reg_rvalid;
	endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("read answer without read");

	property p_unmapped_zero;
		@(posedge clock) disable iff (!rst_n)
		reg_rd && !map_hit |=> reg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped offset not zero");

	property p_read_view;
		@(posedge clock) disable iff (!rst_n)
		reg_rd && map_hit |=> reg_rdata[`HCF_BIT_ROM_VALID] == $past(rom_image_valid_r)
			&& reg_rdata[`HCF_BIT_SWAP_BYPASS] == $past(swap_bypass_r)
			&& reg_rdata[`HCF_BIT_LATE_ACK] == $past(late_ack_permit_r)
			&& reg_rdata[`HCF_BIT_CFG_OWNER] == $past(cfg_owner_r);
	endproperty
	a_read_view: assert property (p_read_view) else $error("read view wrong");
endmodule : hcf_host_ctrl

// File: sim/hcf_node_model.sv
// Remote serial-bus node model issuing asynchronous requests to this node
`timescale 1ns/1ps
module hcf_node_model (
	input  wire logic          clock,
	output logic               req_valid,
	output hcf_pkg::hcf_req_type req_kind
);
	import hcf_pkg::*;

	initial begin
		req_valid = 1'b0;
		req_kind  = HCF_REQ_OTHER;
	end

	// One request per call; kind lines scrambled once released, stale kinds must not be trusted
	task send(input hcf_req_type k);
		@(posedge clock);
		req_valid <= 1'b1;
		req_kind  <= k;
		@(posedge clock);
		req_valid <= 1'b0;
		req_kind  <= hcf_req_type'(~k);
	endtask : send
endmodule : hcf_node_model

// File: sim/tb_top.sv
// Self-checking testbench of the host control upper flags block
`timescale 1ns/1ps
`include "hcf_regs.svh"
module tb_top;
	import hcf_pkg::*;

	logic        clock, rst_n, reg_wr, reg_rd, reg_rvalid, link_active, sw_reset, bus_reset;
	logic        bib_fetch_error, eeprom_load, eeprom_owner, req_valid, ack_valid, rom_serve;
	logic        fwd_valid, tardy_event, rom_regs_reload, rom_image_valid, swap_bypass;
	logic        late_ack_permit, enhancement_config_owner, dma_in_valid, dma_out_valid;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, dma_in_data, dma_out_data;
	hcf_req_type req_kind;
	hcf_ack_type ack_code;
	int          n_errors;
	int          comparisons;

	hcf_host_ctrl #(.DMA_W(32)) dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.link_active(link_active), .sw_reset(sw_reset), .bus_reset(bus_reset),
		.bib_fetch_error(bib_fetch_error), .eeprom_load(eeprom_load), .eeprom_owner(eeprom_owner),
		.req_valid(req_valid), .req_kind(req_kind), .ack_valid(ack_valid), .ack_code(ack_code),
		.rom_serve(rom_serve), .fwd_valid(fwd_valid), .tardy_event(tardy_event),
		.rom_regs_reload(rom_regs_reload), .rom_image_valid(rom_image_valid), .swap_bypass(swap_bypass),
		.late_ack_permit(late_ack_permit), .enhancement_config_owner(enhancement_config_owner),
		.dma_in_valid(dma_in_valid), .dma_in_data(dma_in_data), .dma_out_valid(dma_out_valid),
		.dma_out_data(dma_out_data));

	hcf_node_model node (.clock(clock), .req_valid(req_valid), .req_kind(req_kind));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task conclude;
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr    <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd   <= 1'b0;
		#1;
		chk("read_valid", 32'h1, {31'h0, reg_rvalid});
		chk("read_data", exp, reg_rdata);
	endtask : rd

	// Order of the flag vector: rom valid, swap bypass, late ack, config owner
	task flags(input logic [3:0] exp);
		chk("flags", {28'h0, exp}, {28'h0, rom_image_valid, swap_bypass, late_ack_permit, enhancement_config_owner});
	endtask : flags

	// 0 bus reset, 1 software reset, 2 fetch error, 3 EEPROM load
	task pulse(input int which, input logic own);
		@(posedge clock);
		case (which)
			0: bus_reset <= 1'b1;
			1: sw_reset <= 1'b1;
			2: bib_fetch_error <= 1'b1;
			default: begin
				eeprom_load  <= 1'b1;
				eeprom_owner <= own;
			end
		endcase
		@(posedge clock);
		{bus_reset, sw_reset, bib_fetch_error, eeprom_load} <= 4'h0;
		#1;
	endtask : pulse

	task req(input hcf_req_type k, input logic v, input hcf_ack_type c, input logic [2:0] sft);
		node.send(k);
		#1;
		chk("ack", {24'h0, v, c, sft}, {24'h0, ack_valid, ack_code, rom_serve, fwd_valid, tardy_event});
	endtask : req

	task set_link(input logic v);
		@(posedge clock);
		link_active <= v;
	endtask : set_link

	task t_reset_and_map;
		#1;
		flags(4'b0001);
		chk("ack_idle", {24'h0, 1'b0, HCF_ACK_COMPLETE, 3'b000},
			{24'h0, ack_valid, ack_code, rom_serve, fwd_valid, tardy_event});
		rd(`HCF_SET_OFS, 32'h0080_0000);
		wr(`HCF_SET_OFS, 32'h7F80_0000);
		flags(4'b0111);
		rd(`HCF_CLR_OFS, 32'h6080_0000);
		wr(`HCF_CLR_OFS, 32'h2080_0000);
		flags(4'b0101);
		wr(`HCF_SET_OFS, 32'h0000_0000);
		rd(`HCF_SET_OFS, 32'h4080_0000);
		wr(8'h58, 32'hFFFF_FFFF);
		rd(8'h58, 32'h0000_0000);
		pulse(3, 1'b0);
		flags(4'b0100);
		pulse(3, 1'b1);
		flags(4'b0101);
	endtask : t_reset_and_map

	task t_rom_image;
		set_link(1'b1);
		wr(`HCF_SET_OFS, 32'h8000_0000);
		flags(4'b0101);
		set_link(1'b0);
		wr(`HCF_SET_OFS, 32'h8000_0000);
		wr(`HCF_CLR_OFS, 32'h8000_0000);
		flags(4'b1101);
		pulse(0, 1'b0);
		chk("reload", 32'h1, {31'h0, rom_regs_reload});
		set_link(1'b1);
		req(HCF_REQ_ROM_BLOCK, 1'b1, HCF_ACK_PENDING, 3'b100);
		req(HCF_REQ_ROM_LOCK, 1'b1, HCF_ACK_PENDING, 3'b100);
		req(HCF_REQ_OTHER, 1'b0, HCF_ACK_PENDING, 3'b010);
		pulse(2, 1'b0);
		flags(4'b0101);
		req(HCF_REQ_ROM_BLOCK, 1'b1, HCF_ACK_TYPE_ERROR, 3'b000);
		pulse(0, 1'b0);
		chk("reload", 32'h0, {31'h0, rom_regs_reload});
		set_link(1'b0);
		wr(`HCF_SET_OFS, 32'hE000_0000);
		pulse(1, 1'b0);
		rd(`HCF_SET_OFS, 32'h0080_0000);
	endtask : t_rom_image

	task t_late_ack;
		hcf_req_type kinds[3];
		kinds = '{HCF_REQ_OTHER, HCF_REQ_ROM_BLOCK, HCF_REQ_ROM_LOCK};
		wr(`HCF_SET_OFS, 32'h2000_0000);
		set_link(1'b1);
		foreach (kinds[i]) req(kinds[i], 1'b1, HCF_ACK_TARDY, 3'b001);
		set_link(1'b0);
		req(HCF_REQ_ROM_BLOCK, 1'b0, HCF_ACK_TARDY, 3'b000);
		wr(`HCF_CLR_OFS, 32'h2000_0000);
		flags(4'b0001);
	endtask : t_late_ack

	task t_dma(input logic byp, input logic [31:0] exp);
		wr(byp ? `HCF_SET_OFS : `HCF_CLR_OFS, 32'h4000_0000);
		rd(`HCF_SET_OFS, {1'b0, byp, 7'h01, 23'h00_0000});
		@(posedge clock);
		dma_in_valid <= 1'b1;
		dma_in_data  <= 32'h1122_3344;
		@(posedge clock);
		dma_in_valid <= 1'b0;
		dma_in_data  <= 32'hEEDD_CCBB;
		#1;
		chk("dma_valid", 32'h1, {31'h0, dma_out_valid});
		chk("dma_data", exp, dma_out_data);
	endtask : t_dma

	initial begin
		n_errors = 0;
		comparisons = 0;
		{rst_n, reg_wr, reg_rd, link_active, sw_reset, bus_reset} = 6'h0;
		{bib_fetch_error, eeprom_load, eeprom_owner, dma_in_valid} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		dma_in_data = 32'h0000_0000;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		t_reset_and_map;
		t_rom_image;
		t_late_ack;
		t_dma(1'b0, 32'h4433_2211);
		t_dma(1'b1, 32'h1122_3344);
		conclude;
	end

	// About 80 cycles expected; a hang is cut well beyond that
	initial begin
		#(2000 * 100);
		n_errors++;
		conclude;
	end
endmodule : tb_top
